// [bel_pkg.sv]
// Package for the bridge error log: register map, bit positions, carriers.
// Assumes a 32-bit APB slave and one 250 MHz clock.
package bel_pkg;

    localparam logic [11:0] BEL_OFF_STATUS   = 12'h880;
    localparam logic [11:0] BEL_OFF_PCI_ADDR = 12'h040;
    localparam logic [12:0] BEL_OFF_PCI_FULL = 13'h1040;
    localparam logic [31:0] BEL_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] BEL_ADDR_RESET   = 32'h0000_0000;

    localparam int BEL_SYS_VALID_BIT = 31;
    localparam int BEL_UNC_B_BIT     = 30;
    localparam int BEL_UNC_A_BIT     = 29;
    localparam int BEL_COR_B_BIT     = 28;
    localparam int BEL_COR_A_BIT     = 27;
    localparam int BEL_NXM_BIT       = 26;
    localparam int BEL_ADDR_PAR_BIT  = 25;
    localparam int BEL_LOST_BIT      = 24;
    localparam int BEL_PIO_BUFFER_OVERFLOW_BIT  = 23;
    localparam int BEL_PCI_VALID_BIT = 4;
    localparam int BEL_INVALID_TRANSLATION_ENTRY_BIT   = 3;
    localparam int BEL_MAB_BIT       = 2;
    localparam int BEL_SYSTEM_ERROR_SEEN_BIT      = 1;
    localparam int BEL_PARITY_ERROR_SEEN_BIT      = 0;

    localparam int BEL_SYS_HI = 30;
    localparam int BEL_SYS_LO = 23;
    localparam int BEL_PCI_HI = 3;
    localparam int BEL_PCI_LO = 0;

    // Hard errors lock the log; correctable ones do not
    localparam logic [31:0] BEL_HARD_MASK = 32'h6680_000F;
    localparam logic [31:0] BEL_W1C_MASK  = 32'h7F80_000F;

    // Error event pulses from system bus, datapath halves and PCI side
    typedef struct packed {
        logic       uncorrectable_ecc_half_b;
        logic       uncorrectable_ecc_half_a;
        logic       correctable_ecc_half_b;
        logic       correctable_ecc_half_a;
        logic       nonexistent_memory;
        logic       sysbus_cmd_addr_parity_error;
        logic       pio_buffer_overflow;
        logic       invalid_translation_entry;
        logic       master_target_abort;
        logic       system_error_seen;
        logic       parity_error_seen;
        logic       special_cycle;
        logic [31:0] pci_addr;
    } bel_events_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [12:0] paddr;
        logic [31:0] pwdata;
    } bel_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } bel_apb_rsp_t;

endpackage : bel_pkg

// [bel_sync.sv]
// Three-stage synchroniser for pin-level error inputs.
// Output changes once the second and third stages agree.
`timescale 1ns/100ps
module bel_sync
    import bel_pkg::*;
#(
    parameter int W = 12
)(
    input  wire logic         clock,    // System clock
    input  wire logic         sys_rst,  // Synchronous reset
    input  wire logic [W-1:0] din,      // Asynchronous levels
    output logic      [W-1:0] dout      // Filtered levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } bel_sync_state_t;

    bel_sync_state_t st;
    bel_sync_state_t next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st.s2[i] == st.s3[i])
                next_st.q[i] = st.s3[i];
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign dout = st.q;
endmodule : bel_sync

// [bel_top.sv]
// Bridge error log: status register, lock logic and PCI failing address.
// Assumes event inputs are single-cycle pulses on the clock domain,
// except the observed bus error lines, which arrive as pin levels.
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
// How it works
// RULE_01: System valid bit is OR of 30:23
// RULE_02: Hard error freezes all but lost bit
// RULE_03: Lock holds until every bit cleared; code releases it once bits 30,29,26,25,23 and 3:0 are clear
// RULE_04: Uncorrectable ECC halves set bits 30,29
// RULE_05: Correctable ECC halves set bits 28,27
// RULE_06: Software clears datapath state first
// RULE_07: Nonexistent memory sets bit 26
// RULE_08: Command/address parity error sets bit 25
// RULE_09: Unloggable error while locked sets bit 24
// RULE_10: Full bridge buffers set bit 23
// RULE_11: PCI valid is OR of 3:0, locks address
// RULE_12: Invalid translation entry sets bit 3
// RULE_13: Target abort sets bit 2, not special
// RULE_14: Observed system error line sets bit 1
// RULE_15: Drive system error on own target abort
// RULE_16: Observed parity error line sets bit 0
// RULE_17: Capture PCI address 31:0 of failure
// RULE_18: Address undefined while PCI valid clear
// RULE_19: Clearing symptoms unlocks system address capture
// RULE_20: Reserved bits 22:5 read zero
module bel_top
(
    input  wire logic         clock,              // 250 MHz clock
    input  wire logic         sys_rst,            // Sync reset, high
    input  wire bel_pkg::bel_apb_req_t apb_req,   // APB request
    output bel_pkg::bel_apb_rsp_t      apb_rsp,   // APB response
    input  wire bel_pkg::bel_events_t  events,    // Error events
    input  wire logic         system_error_seen_pin_n,         // Bus system error in
    input  wire logic         parity_error_seen_pin_n,         // Bus parity error in
    output logic              system_error_seen_out,           // System error out
    output logic              system_error_seen_oe_n,          // System error enable
    output logic              sysbus_capture_lock // Locks sys addr regs
);
    import bel_pkg::*;

    typedef struct packed {
        logic [31:0]  status;
        logic [31:0]  pci_addr;
        logic         system_error_seen_oe_n;
        logic         sys_lock;
        bel_apb_rsp_t rsp;
        logic [1:0]   pin_prev;
    } bel_state_t;

    bel_state_t  st;
    bel_state_t  next_st;
    logic [1:0]  pin_lvl;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic        locked;
    logic        any_err;
    logic        sys_valid;
    logic        pci_valid;
    logic        wr_go;
    logic        rd_go;
    logic        hit_status;
    logic        hit_addr;

    bel_sync #(
        .W (2)
    ) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .din     ({~system_error_seen_pin_n, ~parity_error_seen_pin_n}),
        .dout    (pin_lvl)
    );

    always_comb
    begin
        sys_valid  = |st.status[BEL_SYS_HI:BEL_SYS_LO];  // [RULE_01]
        pci_valid  = |st.status[BEL_PCI_HI:BEL_PCI_LO];  // [RULE_11]
        locked     = |(st.status & BEL_HARD_MASK);       // [RULE_03]
        hit_status = apb_req.paddr == {1'b0, BEL_OFF_STATUS};
        hit_addr   = apb_req.paddr == BEL_OFF_PCI_FULL;
        wr_go      = apb_req.psel && apb_req.penable && apb_req.pwrite;
        rd_go      = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

        set_vec = '0;
        set_vec[BEL_UNC_B_BIT]    = events.uncorrectable_ecc_half_b; // [RULE_04]
        set_vec[BEL_UNC_A_BIT]    = events.uncorrectable_ecc_half_a; // [RULE_04]
        set_vec[BEL_COR_B_BIT]    = events.correctable_ecc_half_b;   // [RULE_05]
        set_vec[BEL_COR_A_BIT]    = events.correctable_ecc_half_a;   // [RULE_05]
        set_vec[BEL_NXM_BIT]      = events.nonexistent_memory;       // [RULE_07]
        set_vec[BEL_ADDR_PAR_BIT] = events.sysbus_cmd_addr_parity_error; // [RULE_08]
        set_vec[BEL_PIO_BUFFER_OVERFLOW_BIT] = events.pio_buffer_overflow;      // [RULE_10]
        set_vec[BEL_INVALID_TRANSLATION_ENTRY_BIT]  = events.invalid_translation_entry; // [RULE_12]
        set_vec[BEL_MAB_BIT]      = events.master_target_abort
                                    && !events.special_cycle;        // [RULE_13]
        set_vec[BEL_SYSTEM_ERROR_SEEN_BIT]     = (pin_lvl[1] && !st.pin_prev[1])
                                    || events.system_error_seen; // [RULE_14]
        set_vec[BEL_PARITY_ERROR_SEEN_BIT]     = (pin_lvl[0] && !st.pin_prev[0])
                                    || events.parity_error_seen; // [RULE_16]
        any_err = |set_vec;

        clr_vec = '0;
        if (wr_go && hit_status)
            clr_vec = apb_req.pwdata & BEL_W1C_MASK;  // [RULE_20]

        next_st          = st;
        next_st.pin_prev = pin_lvl;
        next_st.rsp      = '0;

        // While locked, new symptoms are dropped; set wins over clear
        if (locked)
        begin
            next_st.status = st.status & ~clr_vec;    // [RULE_02]
            if (any_err)
                next_st.status[BEL_LOST_BIT] = 1'b1;  // [RULE_09]
        end
        else
        begin
            next_st.status = (st.status & ~clr_vec) | set_vec;
            // A PCI bit cleared in this cycle leaves the log locked, so the address is free for reuse only from the next cycle
            if ((|set_vec[BEL_PCI_HI:BEL_PCI_LO])
                && !(|(st.status[BEL_PCI_HI:BEL_PCI_LO]
                       & ~clr_vec[BEL_PCI_HI:BEL_PCI_LO])))
                next_st.pci_addr = events.pci_addr;   // [RULE_17]
        end
        next_st.status[BEL_SYS_VALID_BIT] = 1'b0;
        next_st.status[BEL_PCI_VALID_BIT] = 1'b0;
        next_st.status[22:5]              = '0;        // [RULE_20]

        // System address capture locks with a hard system-bus error while the log is unlocked
        // While the log is unlocked, a new hard error wins over a clear in the same cycle
        if (|(set_vec[BEL_SYS_HI:BEL_SYS_LO]
              & BEL_HARD_MASK[BEL_SYS_HI:BEL_SYS_LO]) && !locked)
            next_st.sys_lock = 1'b1;
        else if (|clr_vec[BEL_SYS_HI:BEL_SYS_LO])
            next_st.sys_lock = 1'b0;                   // [RULE_19]

        next_st.system_error_seen_oe_n = !(events.master_target_abort
                              && !events.special_cycle); // [RULE_15]

        // Zero-wait APB: pready in the access cycle
        if (apb_req.psel && !apb_req.penable)
        begin
            next_st.rsp.pready  = 1'b1;
            next_st.rsp.pslverr = !(hit_status || hit_addr);
            if (rd_go && hit_status)
            begin
                next_st.rsp.prdata = st.status;
                next_st.rsp.prdata[BEL_SYS_VALID_BIT] = sys_valid;
                next_st.rsp.prdata[BEL_PCI_VALID_BIT] = pci_valid;
            end
            else if (rd_go && hit_addr)
                next_st.rsp.prdata = st.pci_addr;       // [RULE_18]
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st           <= '0;
            st.status    <= BEL_STATUS_RESET;
            st.pci_addr  <= BEL_ADDR_RESET;
            st.system_error_seen_oe_n <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign apb_rsp             = st.rsp;
    assign system_error_seen_out            = 1'b0;
    assign system_error_seen_oe_n           = st.system_error_seen_oe_n;
    assign sysbus_capture_lock = st.sys_lock;
endmodule : bel_top

// [bel_top_sva.sv]
// Checker for the bridge error log, watching the top module ports.
// Assumes one clock domain and the registered APB answer.
`timescale 1ns/100ps
module bel_top_sva (
    input wire logic                  clock,               // Clock
    input wire logic                  sys_rst,             // Reset
    input wire bel_pkg::bel_apb_req_t apb_req,             // APB in
    input wire bel_pkg::bel_apb_rsp_t apb_rsp,             // APB out
    input wire bel_pkg::bel_events_t  events,              // Events
    input wire logic                  system_error_seen_pin_n,          // Pin in
    input wire logic                  parity_error_seen_pin_n,          // Pin in
    input wire logic                  system_error_seen_out,            // Pin data
    input wire logic                  system_error_seen_oe_n,           // Pin enable
    input wire logic                  sysbus_capture_lock  // Lock
);
    import bel_pkg::*;
    logic rd_st;
    logic wr_sys;
    logic sys_hard;
    logic abort_ns;
    assign rd_st = apb_rsp.pready && apb_req.paddr == {1'b0, BEL_OFF_STATUS};
    assign wr_sys = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == {1'b0, BEL_OFF_STATUS} && |apb_req.pwdata[30:23];
    assign sys_hard = events.uncorrectable_ecc_half_b
        || events.uncorrectable_ecc_half_a || events.nonexistent_memory
        || events.sysbus_cmd_addr_parity_error
        || events.pio_buffer_overflow;
    assign abort_ns = events.master_target_abort && !events.special_cycle;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_system_error_seen_drive: assert property (abort_ns |=> !system_error_seen_oe_n)
        else $error("no system error drive after abort");
    a_system_error_seen_special: assert property (events.master_target_abort
        && events.special_cycle |=> system_error_seen_oe_n)
        else $error("system error driven on special cycle");
    a_system_error_seen_cause: assert property (!system_error_seen_oe_n |-> $past(abort_ns))
        else $error("system error driven without abort");
    a_system_error_seen_data: assert property (system_error_seen_out == 1'b0)
        else $error("system error data not low");
    a_sys_valid: assert property (rd_st |->
        apb_rsp.prdata[31] == |apb_rsp.prdata[30:23])
        else $error("system valid bit wrong");
    a_pci_valid: assert property (rd_st |->
        apb_rsp.prdata[4] == |apb_rsp.prdata[3:0])
        else $error("pci valid bit wrong");
    a_rsv_zero: assert property (rd_st |->
        apb_rsp.prdata[22:5] == 18'h0)
        else $error("reserved bits not zero");
    a_lock_hold: assert property (sysbus_capture_lock && !wr_sys
        |=> sysbus_capture_lock)
        else $error("capture lock dropped without clear");
    a_lock_idle: assert property (!sysbus_capture_lock && !sys_hard
        |=> !sysbus_capture_lock)
        else $error("capture lock set without error");
endmodule : bel_top_sva
bind bel_top bel_top_sva bel_top_sva_i (.clock, .sys_rst, .apb_req,
    .apb_rsp, .events, .system_error_seen_pin_n, .parity_error_seen_pin_n, .system_error_seen_out, .system_error_seen_oe_n,
    .sysbus_capture_lock);

// [bel_pci_agent.sv]
// Far-side bus agents: error lines as pulled-up open-drain wires.
// Assumes the bench commands the agents' own error pulses.
`timescale 1ns/100ps
module bel_pci_agent (
    input wire logic       system_error_seen_oe_n,  // Bridge drives system error
    input wire logic [1:0] agt,        // 1: system error, 0: parity
    output logic           system_error_seen_pin_n, // Resolved wire level
    output logic           parity_error_seen_pin_n  // Resolved wire level
);
    assign system_error_seen_pin_n = !(agt[1] || !system_error_seen_oe_n);
    assign parity_error_seen_pin_n = !agt[0];
endmodule : bel_pci_agent

// [tb.sv]
// Self-checking bench for the bridge error log.
// Assumes the checker and agent files are compiled before it.
`timescale 1ns/100ps
module tb;
    import bel_pkg::*;
    typedef struct packed
    {
        logic [11:0] flags;
        logic [31:0] exp;
    } bel_row_t;
    localparam logic [12:0] ST = {1'b0, BEL_OFF_STATUS};
    localparam logic [12:0] PA = BEL_OFF_PCI_FULL;
    localparam logic [7:0]  SH = BEL_HARD_MASK[30:23];
    logic         clock, sys_rst, system_error_seen_pin_n, parity_error_seen_pin_n;
    logic         system_error_seen_out, system_error_seen_oe_n, lock, erb;
    logic [1:0]   agt;
    logic [31:0]  rd;
    bel_apb_req_t req;
    bel_apb_rsp_t rsp;
    bel_events_t  ev;
    int           failures, total_checks;
    bel_row_t rows [0:10] = '{'{12'h800, 32'hC000_0000},
        '{12'h400, 32'hA000_0000}, '{12'h200, 32'h9000_0000},
        '{12'h100, 32'h8800_0000}, '{12'h080, 32'h8400_0000},
        '{12'h040, 32'h8200_0000}, '{12'h020, 32'h8080_0000},
        '{12'h010, 32'h0000_0018}, '{12'h009, 32'h0000_0000},
        '{12'h004, 32'h0000_0012}, '{12'h002, 32'h0000_0011}};
    bel_top bel_top_i (.clock, .sys_rst, .apb_req(req), .apb_rsp(rsp),
        .events(ev), .system_error_seen_pin_n, .parity_error_seen_pin_n, .system_error_seen_out, .system_error_seen_oe_n,
        .sysbus_capture_lock(lock));
    bel_pci_agent bel_pci_agent_i (.system_error_seen_oe_n, .agt, .system_error_seen_pin_n,
        .parity_error_seen_pin_n);
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task xfer(input logic w, input logic [12:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        req.penable <= 1'b1;
        do
            @(posedge clock);
        while (rsp.pready !== 1'b1 && ++n < 20);
        rd = rsp.prdata;
        erb = rsp.pslverr;
        req <= '0;
        if (n >= 20)
            failures++;
    endtask : xfer
    task pulse(input logic [11:0] f, input logic [31:0] a);
        @(posedge clock);
        ev <= {f, a};
        @(posedge clock);
        ev <= '0;
    endtask : pulse
    task report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial
    begin
        #20000;
        failures++;
        report_and_stop;
    end
    initial
    begin
        sys_rst = 1'b1; req = '0; ev = '0; agt = 2'b00;
        failures = 0; total_checks = 0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        xfer(0, ST, 0); chk(rd, 32'h0);
        xfer(0, PA, 0); chk(rd, 32'h0);
        chk({31'h0, system_error_seen_oe_n}, 32'h1);
        foreach (rows[i])
        begin
            pulse(rows[i].flags, 32'h0);
            xfer(0, ST, 0); chk(rd, rows[i].exp);
            chk(32'(lock), 32'(|(rows[i].exp[30:23] & SH)));
            xfer(1, ST, 32'hFFFF_FFFF);
            xfer(0, ST, 0); chk(rd, 32'h0);
            chk(32'(lock), 32'h0);
        end
        // Second error while locked only marks lost
        pulse(12'h010, 32'h1234_5678);
        pulse(12'h210, 32'h9ABC_DEF0);
        xfer(0, ST, 0); chk(rd, 32'h8100_0018);
        xfer(0, PA, 0); chk(rd, 32'h1234_5678);
        xfer(1, ST, 32'h0000_0008);
        pulse(12'h010, 32'h9ABC_DEF0);
        xfer(0, PA, 0); chk(rd, 32'h9ABC_DEF0);
        xfer(1, ST, 32'hFFFF_FFFF);
        pulse(12'h008, 32'h0);
        repeat (10) @(posedge clock);
        xfer(0, ST, 0); chk(rd & 32'h4, 32'h4);
        xfer(1, ST, 32'hFFFF_FFFF);
        for (int k = 0; k < 2; k++)
        begin
            agt <= 2'b01 << k;
            repeat (3) @(posedge clock);
            agt <= 2'b00;
            repeat (10) @(posedge clock);
            xfer(0, ST, 0); chk(rd, 32'h10 | (32'h1 << k));
            xfer(1, ST, 32'hFFFF_FFFF);
        end
        xfer(0, 13'h0004, 0); chk({31'h0, erb}, 32'h1);
        chk(rd, 32'h0);
        report_and_stop;
    end
endmodule : tb
